// file: logic/sfe_pkg.sv
package sfe_pkg;

    // Opcodes decoded by the command sequencer
    localparam logic [7:0] OPC_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7A;
    localparam logic [7:0] OPC_FAST_ENTER = 8'hA3;
    localparam logic [7:0] OPC_RELEASE_PD = 8'hAB;
    localparam logic [7:0] OPC_POWER_DOWN = 8'hB9;

    // Frame lengths in serial clock bits
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR_FRAME = 6'h20;
    localparam logic [5:0] BITS_FAST_FRAME = 6'h20;
    localparam logic [5:0] BITS_SAT = 6'h3F;
    localparam logic [5:0] BIT_ONE = 6'h01;

    // Address layout: 64 blocks of 64KB
    localparam int BLK_LSB = 16;
    localparam int BLK_W = 6;
    localparam logic [6:0] BLK_COUNT = 7'h40;
    localparam logic [6:0] BLK_ONE = 7'h01;
    localparam logic [2:0] BP_LVL_ONE = 3'h1;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned RESUME_WIP_NS = 200;
    localparam int unsigned RESUME_WIP_CYC = RESUME_WIP_NS / CLK_PERIOD_NS;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_SUSP = 2'b11
    } sfe_state_t;

    typedef enum logic [1:0] {
        JOB_NONE  = 2'b00,
        JOB_BLOCK = 2'b01,
        JOB_CHIP  = 2'b10,
        JOB_PROG  = 2'b11
    } sfe_job_t;

    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic si;
    } sfe_pins_t;

    typedef struct packed {
        logic write_in_progress;
        logic write_enable_latch;
        logic suspend_flag;
        logic high_performance_mode;
    } sfe_stat_t;

    typedef struct packed {
        sfe_pins_t   meta;
        sfe_pins_t   sync;
        sfe_pins_t   prev;
        logic [5:0]  cnt;
        logic [7:0]  opc;
        logic [23:0] shift;
        sfe_state_t  state;
        sfe_job_t    job;
        logic [31:0] remain;
        logic [5:0]  tgt;
        logic        done;
        sfe_stat_t   stat;
    } sfe_regs_t;

    // Pins rest at idle levels so reset never fakes a select edge
    localparam sfe_pins_t PINS_IDLE = 3'h2;

    localparam sfe_regs_t REGS_RESET = '{
        meta: PINS_IDLE, sync: PINS_IDLE, prev: PINS_IDLE,
        state: ST_IDLE, job: JOB_NONE, default: '0};

endpackage : sfe_pkg

// file: logic/sfe_ctrl.sv
// Summary of operation
// R1 - Block erase needs write enable latch set
// R2 - Block erase frame: opcode plus 3 address bytes
// R3 - Select must rise right after last address bit
// R4 - Block erase self-timed, busy flag held meanwhile
// R5 - Write enable latch cleared before erase ends
// R6 - Protected target block is never erased
// R7 - Two chip erase opcodes, need write enable
// R8 - Select rises after eighth bit, else dropped
// R9 - Chip erase busy, then clears busy and latch
// R10 - Chip erase only with no protection bits
// R11 - Suspend pauses block erase or page program
// R12 - No erase or status write while suspended
// R13 - Suspend ignored during chip erase
// R14 - Program suspend only during page program
// R15 - Resume only when suspended and not busy
// R16 - Resume clears suspend, busy within 200 ns
// R17 - Fast mode entry: opcode plus three dummies
// R18 - Host enters fast mode before fast reads
// R19 - Power-down opcodes leave fast mode
// R20 - While busy only suspend is obeyed
`timescale 1ns/10ps
module sfe_ctrl
    import sfe_pkg::*;
#(
    parameter int unsigned BLOCK_ERASE_TIME_US  = 1000,
    parameter int unsigned CHIP_ERASE_TIME_US   = 4000,
    parameter int unsigned PAGE_PROGRAM_TIME_US = 100
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_cs_b_in,
    input  wire logic       spi_si_in,
    input  wire logic [4:0] block_protect_bits_in,
    input  wire logic       write_enable_set_in,
    input  wire logic       page_program_start_in,
    output sfe_stat_t       status_out,
    output sfe_job_t        active_job_out,
    output logic [5:0]      target_block_out,
    output logic            op_done_out
);

    localparam logic [31:0] BLOCK_ERASE_CYC =
        32'(BLOCK_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [31:0] CHIP_ERASE_CYC =
        32'(CHIP_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam logic [31:0] PAGE_PROGRAM_CYC =
        32'(PAGE_PROGRAM_TIME_US * NS_PER_US / CLK_PERIOD_NS);
    localparam int RES_MAX = RESUME_WIP_CYC;

    sfe_regs_t q;
    sfe_regs_t d;

    logic sclk_rise;
    logic cs_rise;
    logic cs_fall;
    logic len8;
    logic len32;

    // Protection: upper 2^(level-1) blocks, high bits protect all
    function automatic logic blk_prot(
        input logic [5:0] blk,
        input logic [4:0] bp
    );
        logic [6:0] span;
        span = BLK_ONE << (bp[2:0] - BP_LVL_ONE);
        blk_prot = (bp[4:3] != 2'b00) ||
                   ((bp[2:0] != 3'b000) &&
                    (({1'b0, blk} + span) >= BLK_COUNT));
    endfunction : blk_prot

    // Edges are taken from the second and third stages only
    assign sclk_rise = q.sync.sclk & ~q.prev.sclk;
    assign cs_rise = q.sync.cs_b & ~q.prev.cs_b;
    assign cs_fall = ~q.sync.cs_b & q.prev.cs_b;
    assign len8 = (q.cnt == BITS_OPCODE);
    assign len32 = (q.cnt == BITS_ADDR_FRAME);

    // Next-state logic for the whole sequencer
    always_comb begin
        d = q;
        d.meta.sclk = spi_sclk_in;
        d.meta.cs_b = spi_cs_b_in;
        d.meta.si = spi_si_in;
        d.sync = q.meta;
        d.prev = q.sync;
        d.done = 1'b0;

        // Frame shifter; count saturates so long frames never alias
        if (cs_fall) begin
            d.cnt = '0;
        end else if (!q.sync.cs_b && sclk_rise) begin
            d.shift = {q.shift[22:0], q.sync.si};
            if (q.cnt == (BITS_OPCODE - BIT_ONE)) begin
                d.opc = {q.shift[6:0], q.sync.si};
            end
            if (q.cnt != BITS_SAT) begin
                d.cnt = q.cnt + BIT_ONE;
            end
        end

        // Self-timed engine runs only while busy
        if (q.state == ST_BUSY) begin
            if (q.remain <= CNT_ONE) begin
                d.state = ST_IDLE; // R4
                d.job = JOB_NONE;
                d.stat.write_enable_latch = 1'b0; // R9
                d.done = 1'b1;
            end else begin
                d.remain = q.remain - CNT_ONE;
            end
        end

        // Write enable is ignored while an operation runs
        if (write_enable_set_in && q.state != ST_BUSY) begin
            d.stat.write_enable_latch = 1'b1; // R20
        end

        // Page program start from the neighbouring program path
        if (page_program_start_in && q.state == ST_IDLE &&
            q.stat.write_enable_latch) begin
            d.state = ST_BUSY;
            d.job = JOB_PROG;
            d.remain = PAGE_PROGRAM_CYC;
            d.stat.write_enable_latch = 1'b0;
        end

        // Commands execute on chip select rising
        if (cs_rise) begin
            if (q.state == ST_BUSY) begin
                // Only suspend gets through; chip erase cannot pause
                if (len8 && q.opc == OPC_SUSPEND &&
                    d.state == ST_BUSY && q.job != JOB_CHIP) begin
                    d.state = ST_SUSP; // R11 R13 R14 R20
                end
            end else if (len8 && q.opc == OPC_RESUME) begin
                if (q.state == ST_SUSP) begin
                    d.state = ST_BUSY; // R15 R16
                    d.stat.write_enable_latch = 1'b0; // R5
                end
            end else if (len32 && q.opc == OPC_BLOCK_ERASE) begin
                // Any address inside the block selects it
                if (d.state == ST_IDLE &&
                    q.stat.write_enable_latch &&
                    !blk_prot(q.shift[BLK_LSB +: BLK_W],
                              block_protect_bits_in)) begin
                    d.state = ST_BUSY; // R1 R2 R3 R6 R12
                    d.job = JOB_BLOCK;
                    d.remain = BLOCK_ERASE_CYC;
                    d.tgt = q.shift[BLK_LSB +: BLK_W];
                    d.stat.write_enable_latch = 1'b0; // R5
                end
            end else if (len8 && (q.opc == OPC_CHIP_ERASE_A ||
                                  q.opc == OPC_CHIP_ERASE_B)) begin
                if (d.state == ST_IDLE &&
                    q.stat.write_enable_latch &&
                    block_protect_bits_in == '0) begin
                    d.state = ST_BUSY; // R7 R8 R10 R12
                    d.job = JOB_CHIP;
                    d.remain = CHIP_ERASE_CYC;
                    d.stat.write_enable_latch = 1'b0; // R9
                end
            end else if (q.cnt == BITS_FAST_FRAME &&
                         q.opc == OPC_FAST_ENTER) begin
                d.stat.high_performance_mode = 1'b1; // R17
            end else if (q.cnt >= BITS_OPCODE &&
                         (q.opc == OPC_RELEASE_PD ||
                          q.opc == OPC_POWER_DOWN)) begin
                d.stat.high_performance_mode = 1'b0; // R19
            end
        end

        // Status flags follow the state so they can never disagree
        d.stat.write_in_progress = (d.state == ST_BUSY);
        d.stat.suspend_flag = (d.state == ST_SUSP);
    end

    // Single state register; reset loads constants only
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign status_out = q.stat;
    assign active_job_out = q.job;
    assign target_block_out = q.tgt;
    assign op_done_out = q.done;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Block erase may only start with the latch set
    chk_block_latch_gate: assert property ( // R1
        $rose(q.job == JOB_BLOCK) |-> $past(q.stat.write_enable_latch))
        else $error("block erase started without write enable");

    // Block erase starts only on a rise after exactly 32 bits
    chk_block_frame_len: assert property ( // R3
        $rose(q.job == JOB_BLOCK) |->
            $past(cs_rise) && $past(q.cnt) == BITS_ADDR_FRAME)
        else $error("block erase frame length wrong");

    // Busy raised with the full erase time loaded
    chk_block_busy_load: assert property ( // R4
        $rose(q.job == JOB_BLOCK) |->
            q.stat.write_in_progress && q.remain == BLOCK_ERASE_CYC)
        else $error("block erase not busy with full time");

    // Latch never stands while an operation runs
    chk_busy_latch_low: assert property ( // R5
        q.stat.write_in_progress |-> !q.stat.write_enable_latch)
        else $error("write enable latch set while busy");

    // Protected block never erased
    chk_block_protect: assert property ( // R6
        $rose(q.job == JOB_BLOCK) |->
            !blk_prot(q.tgt, $past(block_protect_bits_in)))
        else $error("protected block erased");

    // Chip erase only with all protection bits clear
    chk_chip_protect: assert property ( // R10
        $rose(q.job == JOB_CHIP) |->
            $past(block_protect_bits_in) == '0 &&
            $past(q.cnt) == BITS_OPCODE)
        else $error("chip erase under protection or bad frame");

    // Chip erase is never suspended
    chk_chip_no_susp: assert property ( // R13
        q.job == JOB_CHIP |-> !q.stat.suspend_flag)
        else $error("chip erase suspended");

    // Resume only from suspended and idle busy flag
    chk_resume_gate: assert property ( // R15
        $fell(q.stat.suspend_flag) |->
            $past(cs_rise) && $past(q.opc) == OPC_RESUME &&
            !$past(q.stat.write_in_progress))
        else $error("resume accepted in wrong state");

    // Busy returns within the resume window
    chk_resume_busy: assert property ( // R16
        $fell(q.stat.suspend_flag) |->
            ##[0:RES_MAX] q.stat.write_in_progress)
        else $error("busy not raised after resume");

    // Busy device ignores everything but suspend
    chk_busy_ignores: assert property ( // R20
        q.state == ST_BUSY && cs_rise && q.opc != OPC_SUSPEND &&
        q.remain > CNT_ONE |=>
            q.job == $past(q.job) &&
            q.stat.high_performance_mode ==
                $past(q.stat.high_performance_mode) &&
            q.stat.write_in_progress)
        else $error("command obeyed while busy");

    // Power-down opcodes leave fast mode
    chk_fast_exit: assert property ( // R19
        cs_rise && q.state != ST_BUSY && q.cnt >= BITS_OPCODE &&
        (q.opc == OPC_RELEASE_PD || q.opc == OPC_POWER_DOWN) |=>
            !q.stat.high_performance_mode)
        else $error("fast mode not left");

    // Chip erase may only start with the latch set
    chk_chip_latch_gate: assert property ( // R7
        $rose(q.job == JOB_CHIP) |-> $past(q.stat.write_enable_latch))
        else $error("chip erase started without write enable");

    // Chip erase starts busy with its full time loaded
    chk_chip_busy_load: assert property ( // R9
        $rose(q.job == JOB_CHIP) |->
            q.stat.write_in_progress && q.remain == CHIP_ERASE_CYC)
        else $error("chip erase not busy with full time");

    // Completion leaves the device idle with the latch clear
    chk_done_clears: assert property ( // R9
        q.done |->
            !q.stat.write_in_progress && !q.stat.write_enable_latch &&
            q.job == JOB_NONE)
        else $error("job end left busy, latch or job set");

    // Suspend entered only from a running job by its opcode
    chk_susp_entry: assert property ( // R11
        $rose(q.stat.suspend_flag) |->
            $past(q.state) == ST_BUSY && $past(q.opc) == OPC_SUSPEND)
        else $error("suspend entered from wrong state");

    // Remaining time is frozen while suspended
    chk_susp_frozen: assert property ( // R11
        q.state == ST_SUSP |=> q.remain == $past(q.remain))
        else $error("remaining time moved while suspended");

    // No new job may start while suspended
    chk_susp_no_start: assert property ( // R12
        q.state == ST_SUSP |=> q.job == $past(q.job))
        else $error("job started while suspended");

    // Only block erase or page program can be suspended
    chk_susp_job: assert property ( // R14
        q.stat.suspend_flag |->
            q.job == JOB_BLOCK || q.job == JOB_PROG)
        else $error("suspended without a suspendable job");

    // Accepted resume clears suspend and raises busy together
    chk_resume_clears: assert property ( // R16
        cs_rise && len8 && q.opc == OPC_RESUME && q.state == ST_SUSP |=>
            !q.stat.suspend_flag && q.stat.write_in_progress)
        else $error("resume did not restart the job");

    // A full entry frame turns fast mode on when not busy
    chk_fast_enter: assert property ( // R17
        cs_rise && q.state != ST_BUSY && q.cnt == BITS_FAST_FRAME &&
        q.opc == OPC_FAST_ENTER |=> q.stat.high_performance_mode)
        else $error("fast mode not entered");

    // Fast mode comes on only after an entry frame of exact length
    chk_fast_len: assert property ( // R17
        $rose(q.stat.high_performance_mode) |->
            $past(cs_rise) && $past(q.cnt) == BITS_FAST_FRAME)
        else $error("fast mode entered on a bad frame");

    // Suspend during chip erase leaves the erase running
    chk_chip_susp_run: assert property ( // R13
        q.job == JOB_CHIP && q.state == ST_BUSY && q.remain > CNT_ONE |=>
            q.stat.write_in_progress)
        else $error("chip erase stopped early");

    // Main scenarios the bench is meant to reach
    cov_block_done: cover property (
        q.job == JOB_BLOCK ##1 q.done);
    cov_suspend_resume: cover property (
        $rose(q.stat.suspend_flag) ##[1:1000]
        $fell(q.stat.suspend_flag));
    cov_chip_start: cover property ($rose(q.job == JOB_CHIP));
    cov_fast_enter: cover property (
        $rose(q.stat.high_performance_mode));
    cov_prog_suspend: cover property (
        $rose(q.stat.suspend_flag) && q.job == JOB_PROG);

endmodule : sfe_ctrl

// file: verification/sfe_host.sv
`timescale 1ns/10ps
// Serial host: shifts bits out MSB first, its clock idles low between frames
module sfe_host (
    input  wire logic clk_in,
    output logic      sclk_out,
    output logic      cs_b_out,
    output logic      si_out
);
    initial begin
        sclk_out = 1'b0;
        cs_b_out = 1'b1;
        si_out   = 1'b0;
    end

    // Frame of nbits taken from the top of data; 8 clocks per serial bit
    task automatic frame(input logic [31:0] data,
                         input int nbits);
        logic [31:0] sh;
        sh = data;
        @(posedge clk_in) cs_b_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < nbits; i++) begin
            si_out <= sh[31];
            sh = sh << 1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        cs_b_out <= 1'b1;
        si_out   <= ~si_out;  // Last data bit inverted, so no stale data is left
        repeat (8) @(posedge clk_in);
    endtask : frame
endmodule : sfe_host

// file: verification/sfe_ctrl_tb.sv
`timescale 1ns/10ps
module sfe_ctrl_tb;
    import sfe_pkg::*;
    logic        ref_clk_in  = 1'b0;
    logic        rst_b_in    = 1'b0;
    logic        sclk;
    logic        cs_b;
    logic        si;
    logic [4:0]  bp          = 5'h00;
    logic        we_set      = 1'b0;
    logic        pp_start    = 1'b0;
    sfe_stat_t   stat;
    sfe_job_t    job;
    logic [5:0]  tgt;
    logic        done;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    logic [31:0] seed        = 32'hc7f5_7e7f;
    logic [23:0] addr;

    always #25 ref_clk_in = ~ref_clk_in;

    // Erase times shortened so suspend frames still land mid-job
    sfe_ctrl #(.BLOCK_ERASE_TIME_US(30), .CHIP_ERASE_TIME_US(40),
               .PAGE_PROGRAM_TIME_US(20)) sfe_ctrl_inst (
        .ref_clk_in            (ref_clk_in),
        .rst_b_in              (rst_b_in),
        .spi_sclk_in           (sclk),
        .spi_cs_b_in           (cs_b),
        .spi_si_in             (si),
        .block_protect_bits_in (bp),
        .write_enable_set_in   (we_set),
        .page_program_start_in (pp_start),
        .status_out            (stat),
        .active_job_out        (job),
        .target_block_out      (tgt),
        .op_done_out           (done)
    );

    sfe_host sfe_host_inst (
        .clk_in   (ref_clk_in),
        .sclk_out (sclk),
        .cs_b_out (cs_b),
        .si_out   (si)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Protected when high bits set, else top 2^(n-1) blocks for level n
    function automatic logic prot(input logic [5:0] blk, input logic [4:0] b);
        if (b[4:3] != 2'h0 || b[2:0] == 3'h7) return 1'b1;
        if (b[2:0] == 3'h0) return 1'b0;
        return 7'(blk) >= (7'h40 - (7'h01 << (b[2:0] - 3'h1)));
    endfunction : prot

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Sampled at the falling edge, well clear of the design's updates
    task automatic cmp_stat(input sfe_stat_t exp);
        @(negedge ref_clk_in);
        comparisons++;
        if (stat !== exp) begin
            miscompares++;
            $display("mismatch at %0t: status %b not %b", $time, stat, exp);
        end
    endtask : cmp_stat

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: value %h not %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic pulse(input logic prog);
        @(posedge ref_clk_in);
        we_set   <= ~prog;
        pp_start <= prog;
        @(posedge ref_clk_in);
        we_set   <= 1'b0;
        pp_start <= 1'b0;
    endtask : pulse

    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input int n);
        sfe_host_inst.frame({op, a}, n);
    endtask : send

    // Bounded wait for the completion pulse, then all flags must be clear
    task automatic wait_idle();
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 1200 && !seen; i++) begin
            @(negedge ref_clk_in);
            seen = seen | (done === 1'b1);
        end
        cmp_val(8'(seen), 8'h01);
        cmp_stat(4'h0);
    endtask : wait_idle

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        cmp_stat(4'h0);
        addr = 24'(rnd());
        send(OPC_BLOCK_ERASE, addr, 32);
        cmp_stat(4'h0);
        pulse(1'b0);
        send(OPC_BLOCK_ERASE, addr, 31);  // Select rises one bit early
        cmp_stat(4'h4);
        // Random blocks and protect levels; first one is the top block
        for (int n = 0; n < 8; n++) begin
            addr = 24'(rnd());
            if (n == 0) addr[21:16] = 6'h3f;
            @(posedge ref_clk_in);
            bp <= (n < 2) ? 5'(1 - n) : 5'(rnd()) & (n[0] ? 5'h1f : 5'h07);
            pulse(1'b0);
            send(OPC_BLOCK_ERASE, addr, 32);
            if (prot(addr[21:16], bp)) begin
                cmp_stat(4'h4);
            end else begin
                cmp_stat(4'h8);
                cmp_val(8'(tgt), 8'(addr[21:16]));
                cmp_val(8'(job), 8'(JOB_BLOCK));
                wait_idle();
            end
        end
        @(posedge ref_clk_in);
        bp <= 5'h02;
        pulse(1'b0);
        send(OPC_CHIP_ERASE_A, 24'h00_0000, 8);
        cmp_stat(4'h4);
        @(posedge ref_clk_in);
        bp <= 5'h00;
        send(OPC_CHIP_ERASE_B, 24'h00_0000, 9);
        cmp_stat(4'h4);
        // Both chip erase codes; suspend must be ignored meanwhile
        for (int k = 0; k < 2; k++) begin
            pulse(1'b0);
            send(k ? OPC_CHIP_ERASE_B : OPC_CHIP_ERASE_A, 24'h00_0000, 8);
            cmp_stat(4'h8);
            cmp_val(8'(job), 8'(JOB_CHIP));
            send(OPC_SUSPEND, 24'h00_0000, 8);
            cmp_stat(4'h8);
            wait_idle();
        end
        send(OPC_RESUME, 24'h00_0000, 8);
        cmp_stat(4'h0);
        pulse(1'b0);
        send(OPC_BLOCK_ERASE, addr & 24'h00_ffff, 32);
        send(OPC_FAST_ENTER, addr, 32);
        cmp_stat(4'h8);
        send(OPC_SUSPEND, 24'h00_0000, 8);
        cmp_stat(4'h2);
        send(OPC_RESUME, 24'h00_0000, 8);
        cmp_stat(4'h8);
        wait_idle();
        pulse(1'b0);
        pulse(1'b1);
        // Job register updates on the edge pulse returns at
        @(negedge ref_clk_in);
        cmp_val(8'(job), 8'(JOB_PROG));
        send(OPC_SUSPEND, 24'h00_0000, 8);
        cmp_stat(4'h2);
        send(OPC_RESUME, 24'h00_0000, 8);
        cmp_stat(4'h8);
        wait_idle();
        // Fast mode: entry needs the full frame, both exit codes leave it
        send(OPC_FAST_ENTER, addr, 24);
        cmp_stat(4'h0);
        send(OPC_FAST_ENTER, addr, 32);
        cmp_stat(4'h1);
        send(OPC_RELEASE_PD, 24'h00_0000, 8);
        cmp_stat(4'h0);
        send(OPC_FAST_ENTER, 24'(rnd()), 32);
        cmp_stat(4'h1);
        send(OPC_POWER_DOWN, 24'h00_0000, 8);
        cmp_stat(4'h0);
        close_out();
    end
endmodule : sfe_ctrl_tb
